/* File: logic/amp_drive_pkg.sv */
// constants shared by the amplifier drive device end and its controller end
// ****************************************************************************
// ****************************************************************************
package amp_drive_pkg;
  // device byte addresses
  localparam logic [15:0] ADDR_DRIVE_LEVEL = 16'h00ce;
  localparam logic [15:0] ADDR_CAP_HI = 16'h400c;
  localparam logic [15:0] ADDR_CAP_LO = 16'h400d;
  localparam logic [15:0] ADDR_TRIM = 16'h4012;
  localparam logic [15:0] ADDR_ODS_CTRL = 16'h00a9;
  localparam logic [15:0] ADDR_ODS_TIMING = 16'h00aa;
  localparam logic [15:0] ADDR_ODS_DATA = 16'h00ab;
  localparam logic [15:0] ADDR_ODS_RATE = 16'h00ac;
  localparam logic [15:0] ADDR_FSK_DEV = 16'h00ad;
  // field positions
  localparam int TRIM_BOOST_BIT = 4;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FORCE_AMP_ON = 1;
  localparam int CTRL_FORCE_DIV = 2;
  localparam int CTRL_FORCE_LC = 3;
  localparam int CTRL_FSK = 4;
  localparam int CTRL_FORCE_DEV = 5;
  localparam int CTRL_RUNOUT_LSB = 6;
  localparam int TIM_CKDIV_LSB = 0;
  localparam int TIM_EDGE_LSB = 3;
  localparam int TIM_GROUP_LSB = 5;
  // reset values
  localparam logic [7:0] DRIVE_LEVEL_RST = 8'h00;
  localparam logic [8:0] CAP_RST = 9'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // run-out actions
  localparam logic [1:0] RUNOUT_STOP = 2'h0;
  localparam logic [1:0] RUNOUT_REPEAT = 2'h1;
  localparam logic [1:0] RUNOUT_ZEROS = 2'h2;
  localparam logic [1:0] RUNOUT_ONES = 2'h3;
  // controller APB offsets and fields
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam int CMD_WDATA_LSB = 16;
  localparam int CMD_WRITE_BIT = 24;
  localparam int STAT_RDATA_LSB = 8;
  localparam int STAT_READY_BIT = 16;
  // serializer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } ser_state_t;
endpackage : amp_drive_pkg

/* File: logic/amp_link_if.sv */
// byte register link between the controller and the amplifier drive device
`timescale 1ns/1ps
`default_nettype none
interface amp_link_if (
  input wire logic core_clk
);
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic ack;
  logic byte_ready;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output ack, output byte_ready);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input ack, input byte_ready);
endinterface : amp_link_if
`default_nettype wire

/* File: logic/ods_tick.sv */
// periodic one-cycle pulse generator for symbol and edge pacing
`timescale 1ns/1ps
`default_nettype none
module ods_tick #(
  parameter int W = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic tick
);
  logic [W-1:0] count;
  initial begin
    if (W < 2) $error("ods_tick width too small");
  end
  // count up to period-1, pulse, restart; held at zero while not running
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= period - W'(1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick <= 1'b0;
    end
  end
endmodule : ods_tick
`default_nettype wire

/* File: logic/amp_drive_dev.sv */
// amplifier drive registers and output data serializer, device end
`timescale 1ns/1ps
`default_nettype none
module amp_drive_dev (
  input wire logic core_clk,
  input wire logic sys_rst,
  amp_link_if.dev link,
  output logic [4:0] pa_slices,
  output logic [2:0] pa_bias,
  output logic pa_boost,
  output logic [8:0] cap_switch,
  output logic pa_on,
  output logic div_on,
  output logic lc_on,
  output logic [6:0] freq_dev
);
  import amp_drive_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] amp_drive_level;
  logic [8:0] tuning_cap_value;
  logic drive_boost;
  logic [7:0] ods_ctrl;
  logic [7:0] ods_timing;
  logic [7:0] ods_rate;
  logic [6:0] fsk_dev_value;
  logic [7:0] hold_byte;
  logic hold_full;
  logic next_hold_full;
  logic take;

  logic [4:0] driver_slice_count;
  logic [2:0] slice_bias_level;
  logic modulation_select;
  logic force_amp_on;
  logic [1:0] runout;
  logic [2:0] ck_div;
  logic [1:0] edge_time;
  logic [2:0] group_width;

  assign driver_slice_count = amp_drive_level[7:3];
  assign slice_bias_level = amp_drive_level[2:0];
  assign modulation_select = ods_ctrl[CTRL_FSK];
  assign force_amp_on = ods_ctrl[CTRL_FORCE_AMP_ON];
  assign runout = ods_ctrl[CTRL_RUNOUT_LSB +: 2];
  assign ck_div = ods_timing[TIM_CKDIV_LSB +: 3];
  assign edge_time = ods_timing[TIM_EDGE_LSB +: 2];
  assign group_width = ods_timing[TIM_GROUP_LSB +: 3];

  // register writes from the link
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      amp_drive_level <= DRIVE_LEVEL_RST;
      tuning_cap_value <= CAP_RST;
      drive_boost <= 1'b0;
      ods_ctrl <= BYTE_RST;
      ods_timing <= BYTE_RST;
      ods_rate <= BYTE_RST;
      fsk_dev_value <= 7'h00;
      hold_byte <= BYTE_RST;
    end else if (link.wr) begin
      case (link.addr)
        ADDR_DRIVE_LEVEL: amp_drive_level <= link.wdata;
        ADDR_CAP_HI: tuning_cap_value[8] <= link.wdata[0];
        ADDR_CAP_LO: tuning_cap_value[7:0] <= link.wdata;
        ADDR_TRIM: drive_boost <= link.wdata[TRIM_BOOST_BIT];
        ADDR_ODS_CTRL: ods_ctrl <= link.wdata;
        ADDR_ODS_TIMING: ods_timing <= link.wdata;
        ADDR_ODS_DATA: hold_byte <= link.wdata;
        ADDR_ODS_RATE: ods_rate <= link.wdata;
        ADDR_FSK_DEV: fsk_dev_value <= link.wdata[6:0];
        default: ;
      endcase
    end
  end

  // read data and acknowledge, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link.rdata <= BYTE_RST;
      link.ack <= 1'b0;
    end else begin
      link.ack <= link.wr | link.rd;
      case (link.addr)
        ADDR_DRIVE_LEVEL: link.rdata <= amp_drive_level;
        ADDR_CAP_HI: link.rdata <= {7'h00, tuning_cap_value[8]};
        ADDR_CAP_LO: link.rdata <= tuning_cap_value[7:0];
        ADDR_TRIM: link.rdata <= 8'(drive_boost) << TRIM_BOOST_BIT;
        ADDR_ODS_CTRL: link.rdata <= ods_ctrl;
        ADDR_ODS_TIMING: link.rdata <= ods_timing;
        ADDR_ODS_DATA: link.rdata <= hold_byte;
        ADDR_ODS_RATE: link.rdata <= ods_rate;
        ADDR_FSK_DEV: link.rdata <= {1'b0, fsk_dev_value};
        default: link.rdata <= BYTE_RST;
      endcase
    end
  end

  // ****************************************************************
  // holding stage handshake
  // ****************************************************************
  // a load in the same cycle as a take keeps the stage full
  always_comb begin
    next_hold_full = hold_full;
    if (take) next_hold_full = 1'b0;
    if (link.wr && link.addr == ADDR_ODS_DATA) next_hold_full = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hold_full <= 1'b0;
      link.byte_ready <= 1'b1;
    end else begin
      hold_full <= next_hold_full;
      link.byte_ready <= ~next_hold_full;
    end
  end

  // ****************************************************************
  // pacing
  // ****************************************************************
  logic [11:0] sym_period;
  logic [5:0] edge_period;
  logic sym_tick;
  logic edge_tick;
  ser_state_t state;

  // symbol period (ck_div+1)*(rate+1), edge step (ck_div+1)*(edge_time+1)
  // operands widened first so a divide of eight cannot wrap inside the product
  assign sym_period = (12'(ck_div) + 12'h001) * (12'(ods_rate) + 12'h001);
  assign edge_period = (6'(ck_div) + 6'h01) * (6'(edge_time) + 6'h01);

  ods_tick #(.W(12)) sym_pacer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(state == ST_SEND || take), // start on the take so the first symbol is full length like the rest
    .period(sym_period),
    .tick(sym_tick)
  );

  ods_tick #(.W(6)) edge_pacer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .run(1'b1),
    .period(edge_period),
    .tick(edge_tick)
  );

  // ****************************************************************
  // serializer
  // ****************************************************************
  logic [7:0] shifter;
  logic [7:0] last_group;
  logic [2:0] sym_left;

  // no take while disabled, so the holding-stage byte is kept when the enable falls; the byte in the shifter is abandoned
  assign take = hold_full && ods_ctrl[CTRL_EN] &&
    (state == ST_IDLE || (state == ST_SEND && sym_tick && sym_left == 3'h0));

  // symbols leave lsb first, group of group_width+1 symbols per byte
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      shifter <= BYTE_RST;
      last_group <= BYTE_RST;
      sym_left <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take) begin
            shifter <= hold_byte;
            last_group <= hold_byte;
            sym_left <= group_width;
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!ods_ctrl[CTRL_EN]) begin
            state <= ST_IDLE;
          end else if (sym_tick) begin
            if (sym_left != 3'h0) begin
              shifter <= shifter >> 1;
              sym_left <= sym_left - 3'h1;
            end else if (take) begin
              shifter <= hold_byte;
              last_group <= hold_byte;
              sym_left <= group_width;
            end else begin
              sym_left <= group_width;
              case (runout)
                RUNOUT_STOP: state <= ST_IDLE;
                RUNOUT_REPEAT: shifter <= last_group;
                RUNOUT_ZEROS: shifter <= 8'h00;
                RUNOUT_ONES: shifter <= 8'hff;
                default: state <= ST_IDLE;
              endcase
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // analog drive outputs
  // ****************************************************************
  logic tx_active;
  logic symbol;
  logic [4:0] slice_target;

  assign tx_active = state == ST_SEND;
  assign symbol = shifter[0];
  // OOK keys the slices with the symbol, FSK keeps them up while sending
  assign slice_target = (tx_active && (modulation_select || symbol)) ? driver_slice_count : 5'h00;

  // slice count steps one slice per edge tick toward its target, but loads the slice count at once while the amplifier is forced on
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pa_slices <= 5'h00;
    end else if (force_amp_on) begin
      pa_slices <= driver_slice_count;
    end else if (edge_tick && pa_slices < slice_target) begin
      pa_slices <= pa_slices + 5'h01;
    end else if (edge_tick && pa_slices > slice_target) begin
      pa_slices <= pa_slices - 5'h01;
    end
  end

  // power schedule, test forces, deviation and static drive settings
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pa_on <= 1'b0;
      div_on <= 1'b0;
      lc_on <= 1'b0;
      freq_dev <= 7'h00;
      pa_bias <= 3'h0;
      pa_boost <= 1'b0;
      cap_switch <= CAP_RST;
    end else begin
      pa_on <= tx_active || force_amp_on || pa_slices != 5'h00;
      div_on <= tx_active || ods_ctrl[CTRL_FORCE_DIV];
      lc_on <= tx_active || ods_ctrl[CTRL_FORCE_LC];
      if (modulation_select && (ods_ctrl[CTRL_FORCE_DEV] || (tx_active && symbol))) begin
        freq_dev <= fsk_dev_value;
      end else begin
        freq_dev <= 7'h00;
      end
      pa_bias <= slice_bias_level;
      pa_boost <= drive_boost;
      cap_switch <= tuning_cap_value;
    end
  end
endmodule : amp_drive_dev
`default_nettype wire

/* File: logic/amp_drive_host.sv */
// controller end: APB registers that launch byte accesses on the link
`timescale 1ns/1ps
`default_nettype none
module amp_drive_host (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  amp_link_if.host link
);
  import amp_drive_pkg::*;

  logic busy;
  logic [7:0] last_rdata;
  logic cmd_go;

  assign cmd_go = psel && penable && pready && pwrite && paddr == APB_CMD && !busy;

  // ****************************************************************
  // APB slave, answers in the first access cycle
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && paddr == APB_STATUS) begin
        prdata <= {15'h0000, link.byte_ready, last_rdata, 7'h00, busy};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // link access, one strobe cycle then wait for acknowledge
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link.addr <= 16'h0000;
      link.wdata <= 8'h00;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      busy <= 1'b0;
      last_rdata <= 8'h00;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      if (cmd_go) begin
        link.addr <= pwdata[15:0];
        link.wdata <= pwdata[CMD_WDATA_LSB +: 8];
        link.wr <= pwdata[CMD_WRITE_BIT];
        link.rd <= !pwdata[CMD_WRITE_BIT];
        busy <= 1'b1;
      end else if (busy && link.ack) begin
        busy <= 1'b0;
        last_rdata <= link.rdata;
      end
    end
  end
endmodule : amp_drive_host
`default_nettype wire

/* File: test/amp_drive_chk.sv */
// assertions on the byte link between controller and amplifier drive device
`timescale 1ns/1ps
`default_nettype none
module amp_drive_chk
  import amp_drive_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ack,
  input wire logic byte_ready
);
  logic [7:0] lvl_shadow;
  // ****************************************************************
  // shadow of the drive level byte last written over the link
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) lvl_shadow <= DRIVE_LEVEL_RST;
    else if (wr && addr == ADDR_DRIVE_LEVEL) lvl_shadow <= wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ack_follows_req: assert property ((wr || rd) |=> ack)
    else $error("ack did not follow a request");
  a_ack_has_cause: assert property (ack |-> $past(wr || rd))
    else $error("ack without a request");
  a_strobe_single: assert property ((wr || rd) |=> !(wr || rd) ##1 !(wr || rd))
    else $error("strobes too close together");
  a_cap_hi_zero: assert property ((rd && addr == ADDR_CAP_HI) |=> rdata[7:1] == 7'h00)
    else $error("capacitor high byte upper bits not zero");
  a_trim_unused_zero: assert property ((rd && addr == ADDR_TRIM) |=> (rdata & 8'hef) == 8'h00)
    else $error("trim unused bits not zero");
  a_level_readback: assert property ((rd && addr == ADDR_DRIVE_LEVEL) |=> rdata == lvl_shadow)
    else $error("drive level readback differs");
  a_ready_clears: assert property ((wr && addr == ADDR_ODS_DATA) |=> !byte_ready)
    else $error("ready still high after data load");
  a_ready_fall_cause: assert property ($fell(byte_ready) |-> $past(wr && addr == ADDR_ODS_DATA))
    else $error("ready fell without a data load");
endmodule : amp_drive_chk
`default_nettype wire

/* File: test/amp_drive_regs_and_serializer_bench.sv */
// self-checking bench for the amplifier drive controller and device pair
`timescale 1ns/1ps
`default_nettype none
module amp_drive_regs_and_serializer_bench;
  import amp_drive_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0] pa_slices;
  logic [2:0] pa_bias;
  logic pa_boost, pa_on, div_on, lc_on, rd_d;
  logic [8:0] cap_switch;
  logic [6:0] freq_dev, dv;
  logic [31:0] v, sr, seed;
  logic [7:0] rb;
  logic [7:0] notes[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int m, i, cnt, p;
  logic counting = 1'b0;
  amp_link_if link (.core_clk(core_clk));
  amp_drive_dev i_amp_drive_dev (.core_clk(core_clk), .sys_rst(sys_rst), .link(link), .pa_slices(pa_slices),
    .pa_bias(pa_bias), .pa_boost(pa_boost), .cap_switch(cap_switch), .pa_on(pa_on), .div_on(div_on),
    .lc_on(lc_on), .freq_dev(freq_dev));
  amp_drive_host i_amp_drive_host (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  amp_drive_chk i_amp_drive_chk (.core_clk(core_clk), .sys_rst(sys_rst), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .ack(link.ack), .byte_ready(link.byte_ready));
  // clock at 25 MHz
  always #20 core_clk = ~core_clk;
  // ****************************************************************
  // reporting and bus tasks
  // ****************************************************************
  task automatic conclude();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic link_op(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] b);
    logic [31:0] r;
    apb(1'b1, APB_CMD, {7'h00, w, d, a}, r);
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) apb(1'b0, APB_STATUS, 32'h0000_0000, r);
    b = r[15:8];
  endtask : link_op
  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] b;
    link_op(1'b1, a, d, b);
  endtask : wr_b
  task automatic rd_exp(input logic [15:0] a, input logic [7:0] e);
    notes.push_back(e);
    link_op(1'b0, a, 8'h00, rb);
  endtask : rd_exp
  task automatic ready_is(input logic e);
    apb(1'b0, APB_STATUS, 32'h0000_0000, sr);
    chk("byte_ready", e, sr[STAT_READY_BIT]);
  endtask : ready_is
  // watcher: each read answer on the link is compared with the oldest note
  always @(posedge core_clk) begin
    rd_d <= link.rd;
    if (rd_d === 1'b1 && link.ack === 1'b1) begin
      if (notes.size() == 0) chk("unexpected read", 32'h0000_0000, 32'h0000_0001);
      else chk("rdata", notes.pop_front(), link.rdata);
    end
  end
  // counts deviated cycles while a serializer run is watched
  always @(posedge core_clk) begin
    if (counting && freq_dev === dv) cnt++;
  end
  // cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 32'h87c1_a840;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sys_rst = 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    rd_exp(ADDR_DRIVE_LEVEL, DRIVE_LEVEL_RST);
    rd_exp(ADDR_CAP_HI, 8'h00);
    rd_exp(ADDR_CAP_LO, 8'h00);
    rd_exp(ADDR_TRIM, 8'h00);
    ready_is(1'b1);
    // random drive level and capacitor words
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr_b(ADDR_DRIVE_LEVEL, v[7:0]);
      wr_b(ADDR_CAP_HI, v[15:8]);
      wr_b(ADDR_CAP_LO, v[23:16]);
      chk("pa_bias", v[2:0], pa_bias);
      chk("cap_switch", {v[8], v[23:16]}, cap_switch);
      rd_exp(ADDR_CAP_HI, {7'h00, v[8]});
      rd_exp(ADDR_CAP_LO, v[23:16]);
      rd_exp(ADDR_DRIVE_LEVEL, v[7:0]);
    end
    // boost bit, unused bits, then a read-modify-write clear
    wr_b(ADDR_TRIM, 8'hff);
    chk("pa_boost", 1'b1, pa_boost);
    notes.push_back(8'h10);
    link_op(1'b0, ADDR_TRIM, 8'h00, rb);
    wr_b(ADDR_TRIM, rb & 8'hef);
    chk("pa_boost", 1'b0, pa_boost);
    // forced power states pass the slice count straight through
    wr_b(ADDR_ODS_CTRL, 8'h0e);
    chk("forced power", 3'b111, {pa_on, div_on, lc_on});
    chk("pa_slices", v[7:3], pa_slices);
    // serializer in fsk with every run-out action and forced deviation
    dv = 7'h40 | 7'($random(seed));
    wr_b(ADDR_FSK_DEV, {1'b0, dv});
    wr_b(ADDR_ODS_TIMING, 8'he0);
    wr_b(ADDR_ODS_RATE, 8'h04);
    p = 5;
    for (m = 0; m < 5; m++) begin
      wr_b(ADDR_ODS_CTRL, 8'h00);
      wr_b(ADDR_ODS_DATA, (m == 4) ? 8'h00 : 8'h0f);
      ready_is(1'b0);
      cnt = 0;
      counting <= 1'b1;
      wr_b(ADDR_ODS_CTRL, {2'(m), (m == 4), 5'b1_0001});
      repeat (20 * p) @(posedge core_clk);
      counting <= 1'b0;
      @(posedge core_clk);
      if (m == 0 || m == 2) chk("deviated cycles", 4 * p, cnt);
      if (m == 1) chk("repeat cycles", 1, cnt >= 8 * p);
      if (m == 3) chk("ones cycles", 1, cnt >= 12 * p);
      if (m == 4) chk("forced deviation", 1, cnt >= 8 * p);
      chk("lc_on", (m >= 1 && m <= 3), lc_on);
      ready_is(1'b1);
    end
    // on-off keying ramps the slices one step per edge period
    wr_b(ADDR_DRIVE_LEVEL, 8'hf8);
    wr_b(ADDR_ODS_TIMING, 8'hf8);
    wr_b(ADDR_ODS_CTRL, 8'h00);
    wr_b(ADDR_ODS_DATA, 8'hff);
    wr_b(ADDR_ODS_CTRL, 8'hc1);
    chk("slices ramping", 1, pa_slices < 5'h1f);
    repeat (200) @(posedge core_clk);
    chk("slices ramped", 5'h1f, pa_slices);
    chk("pa_on", 1, pa_on);
    wr_b(ADDR_ODS_CTRL, 8'h00);
    chk("pa held while ramping down", 1, pa_on);
    chk("lc_on off", 0, lc_on);
    conclude();
  end
endmodule : amp_drive_regs_and_serializer_bench
`default_nettype wire
